// ### inc/card_seq_consts.vh
/*
  Constants for the card activation sequencer: APB offsets, field
  positions, reset values and timing counts. Assumes a 25 MHz pclk.
*/
`ifndef CARD_SEQ_CONSTS_VH
`define CARD_SEQ_CONSTS_VH

`define CLK_MHZ 25
`define ACT_STEP_US 10
`define ACT_STEP_CYC (`ACT_STEP_US * `CLK_MHZ)
`define DEACT_TOTAL_US 100
`define DEACT_STEPS 5
`define DEACT_STEP_US 10
`define DEACT_STEP_CYC (`DEACT_STEP_US * `CLK_MHZ)
`define DEBOUNCE_MS 10
`define DEBOUNCE_CYC (`DEBOUNCE_MS * 1000 * `CLK_MHZ)
`define SUP_SHORT_MS 10
`define SUP_SHORT_CYC (`SUP_SHORT_MS * 1000 * `CLK_MHZ)
`define SUP_LONG_MS 20
`define SUP_LONG_CYC (`SUP_LONG_MS * 1000 * `CLK_MHZ)
`define LINE_GUARD_CYC 3'h7

`define REG_STEP_LEN 12'h000
`define REG_STATUS 12'h004
`define STEP_LEN_W 12
`define STEP_LEN_RST 12'h0FA

`define ST_STATE_LSB 0
`define ST_PRESENT 4
`define ST_FAULT_LATCH 5
`define ST_IRQ_LOW 6
`define ST_OVERLOAD 7
`define ST_OVERHEAT 8
`define ST_BOOST_FAULT 9
`define ST_SUPERVISOR 10
`define ST_CLK_RUN 11
`define ST_SUPPLY_EN 12

`define SYNC_W 19
`define SYNC_RST 19'h00005

`endif

// ### core/card_clock_gen.v
/*
  Card clock divider: divides the synchronised oscillator level by
  1, 2, 4 or 8. Assumes osc_level and selects are already in the pclk
  domain and that the oscillator is well below half of pclk.
*/
`timescale 1ns/1ns
module card_clock_gen (
  input wire pclk,
  input wire presetn,
  input wire osc_level,
  input wire clock_div_sel_a,
  input wire clock_div_sel_b,
  input wire run,
  output reg card_clk,
  output reg running
);
  reg osc_q;
  reg [3:0] cnt;
  reg [3:0] half;
  reg [3:0] next_half;
  wire osc_edge;

  assign osc_edge = osc_level ^ osc_q;

  always @* begin
    case ({clock_div_sel_a, clock_div_sel_b})
      2'b00: next_half = 4'h8;
      2'b01: next_half = 4'h4;
      2'b11: next_half = 4'h2;
      default: next_half = 4'h1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q <= 1'b0;
      cnt <= 4'h0;
      half <= 4'h8;
      card_clk <= 1'b0;
      running <= 1'b0;
    end else begin
      osc_q <= osc_level;
      if (!running) begin
        card_clk <= 1'b0;
        cnt <= 4'h0;
        half <= next_half;
        if (run) begin
          running <= 1'b1;
        end
      end else if (!run && !card_clk) begin
        running <= 1'b0; // Stop only while low, no short high pulse
      end else if (osc_edge) begin
        if (cnt == half - 4'h1) begin
          cnt <= 4'h0;
          card_clk <= ~card_clk;
          if (card_clk) begin
            half <= next_half; // Adopt new ratio at period end only
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // card_clock_gen

// ### core/card_seq.v
/*
  Smart card activation sequencer: activation and deactivation of
  boost, supply, data lines, clock and reset; fault monitoring,
  presence debounce, supply supervisor and an APB status port.
  Assumes all card/host pins are asynchronous and an external wire
  model resolves the open-drain and two-way pins from the enables.
*/
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "card_seq_consts.vh"

// Summary of operation
// - Host pulling activate_cmd_n low starts the activation sequence.
// - Activation order: boost, supply, data lines, card clock, card reset.
// - A falling card_reset_ctrl_in in the window starts the card clock at once.
// - Host raising activate_cmd_n starts the automatic deactivation.
// - Deactivation order: reset low, clock stop, lines low, supply off, boost off.
// - Deactivation completes within 100 us of starting.
// - Overload, removal, heat, core drop or boost fault: irq low and deactivate.
// - After deactivation irq returns high when command is high, unless card removed.
// - Presence is high-active OR low-active input; open inputs count inactive.
// - Combined presence is debounced 10 ms before reaching the irq line.
// - Card insertion shows as irq rising from low to high.
// - Card removal drives irq low and deactivates the card.
// - Data line and two extra lines pass both ways between host and card.
// - Supervisor pulse is 10 ms with threshold pin grounded, 20 ms otherwise.
// - Card supply level is high when level select is high, else low.
// - Irq is open-drain active low: it only pulls low.
// - Divider select 00 gives /8, 01 /4, 11 /2, 10 undivided.
// - Clock ratio changes happen without short or spurious card clock pulses.
// - No activation unless a card is present.
// - Supply overload during operation causes automatic deactivation.
module card_seq #(
  parameter [19:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
  parameter [19:0] SUP_SHORT_CYCLES = `SUP_SHORT_CYC,
  parameter [19:0] SUP_LONG_CYCLES = `SUP_LONG_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire activate_cmd_n,
  input wire card_reset_ctrl_in,
  input wire presence_hi,
  input wire presence_lo,
  input wire supply_overload,
  input wire overheat,
  input wire boost_fault,
  input wire core_supply_low,
  input wire supervisor_threshold_adj,
  input wire clock_div_sel_a,
  input wire clock_div_sel_b,
  input wire supply_level_sel,
  input wire osc_input,
  input wire host_side_data_line_in,
  output wire host_side_data_line_out,
  output wire host_side_data_line_oe,
  input wire host_side_extra_line_a_in,
  output wire host_side_extra_line_a_out,
  output wire host_side_extra_line_a_oe,
  input wire host_side_extra_line_b_in,
  output wire host_side_extra_line_b_out,
  output wire host_side_extra_line_b_oe,
  input wire card_side_data_line_in,
  output wire card_side_data_line_out,
  output wire card_side_data_line_oe,
  input wire card_side_extra_line_a_in,
  output wire card_side_extra_line_a_out,
  output wire card_side_extra_line_a_oe,
  input wire card_side_extra_line_b_in,
  output wire card_side_extra_line_b_out,
  output wire card_side_extra_line_b_oe,
  output wire fault_presence_irq_n_out,
  output reg fault_presence_irq_n_oe,
  output reg boost_enable,
  output reg card_supply_enable,
  output reg supply_level_high,
  output reg card_reset,
  output wire card_clk,
  output reg supervisor_hold
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_ACT = 4'b0010;
  localparam [3:0] S_ON = 4'b0100;
  localparam [3:0] S_DEACT = 4'b1000;

  reg [`SYNC_W-1:0] sync1;
  reg [`SYNC_W-1:0] sync2;
  reg [3:0] state;
  reg [2:0] step;
  reg [11:0] timer;
  reg [`STEP_LEN_W-1:0] step_len;
  reg lines_en;
  reg clk_run;
  reg rst_en;
  reg card_reset_ctrl_in_q;
  reg fault_latch;
  reg presence_hi_db;
  reg [19:0] deb_cnt;
  reg [19:0] sup_cnt;
  wire cmd_n_s, card_reset_ctrl_in_s, presence_hi_hi_s, presence_hi_lo_s, overload_s, heat_s;
  wire boost_f_s, core_low_s, adj_s, div_a_s, div_b_s, level_s, osc_s;
  wire [2:0] host_in_s;
  wire [2:0] card_in_s;
  wire [2:0] host_oe;
  wire [2:0] card_oe;
  wire presence_hi_raw, sup_active, fault_now, stop_req, card_reset_ctrl_in_fall, clk_running;
  wire step_done, deact_done, bus_wr, bus_setup, addr_ok;

  // Every card and host pin passes two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= `SYNC_RST;
      sync2 <= `SYNC_RST;
    end else begin
      sync1 <= {card_side_extra_line_b_in, card_side_extra_line_a_in, card_side_data_line_in,
                host_side_extra_line_b_in, host_side_extra_line_a_in, host_side_data_line_in,
                osc_input, supply_level_sel, clock_div_sel_b, clock_div_sel_a,
                supervisor_threshold_adj, core_supply_low, boost_fault, overheat,
                supply_overload, presence_hi, presence_lo, card_reset_ctrl_in, activate_cmd_n};
      sync2 <= sync1;
    end
  end

  assign cmd_n_s = sync2[0];
  assign card_reset_ctrl_in_s = sync2[1];
  assign presence_hi_lo_s = sync2[2];
  assign presence_hi_hi_s = sync2[3];
  assign overload_s = sync2[4];
  assign heat_s = sync2[5];
  assign boost_f_s = sync2[6];
  assign core_low_s = sync2[7];
  assign adj_s = sync2[8];
  assign div_a_s = sync2[9];
  assign div_b_s = sync2[10];
  assign level_s = sync2[11];
  assign osc_s = sync2[12];
  assign host_in_s = sync2[15:13];
  assign card_in_s = sync2[18:16];

  // Open inputs are held inactive by pad pulls outside this block
  assign presence_hi_raw = presence_hi_hi_s | ~presence_hi_lo_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presence_hi_db <= 1'b0;
      deb_cnt <= 20'h00000;
    end else if (presence_hi_raw == presence_hi_db) begin
      deb_cnt <= 20'h00000;
    end else if (deb_cnt >= DEBOUNCE_CYCLES - 20'h00001) begin
      presence_hi_db <= presence_hi_raw;
      deb_cnt <= 20'h00000;
    end else begin
      deb_cnt <= deb_cnt + 20'h00001;
    end
  end

  // Supervisor: hold while supply is low, then for the pulse length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_cnt <= 20'h00000;
      supervisor_hold <= 1'b0;
    end else begin
      if (core_low_s) begin
        sup_cnt <= adj_s ? SUP_LONG_CYCLES : SUP_SHORT_CYCLES;
      end else if (sup_cnt != 20'h00000) begin
        sup_cnt <= sup_cnt - 20'h00001;
      end
      supervisor_hold <= sup_active;
    end
  end

  assign sup_active = core_low_s | (sup_cnt != 20'h00000);
  assign fault_now = overload_s | heat_s | boost_f_s | sup_active;
  // Removal uses the raw level so the card is protected before debounce ends
  assign stop_req = cmd_n_s | fault_now | ~presence_hi_raw;
  assign card_reset_ctrl_in_fall = card_reset_ctrl_in_q & ~card_reset_ctrl_in_s;
  assign step_done = timer >= step_len;
  assign deact_done = timer >= `DEACT_STEP_CYC - 1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      step <= 3'h0;
      timer <= 12'h000;
      boost_enable <= 1'b0;
      card_supply_enable <= 1'b0;
      supply_level_high <= 1'b0;
      lines_en <= 1'b0;
      clk_run <= 1'b0;
      rst_en <= 1'b0;
      card_reset_ctrl_in_q <= 1'b1;
      card_reset <= 1'b0;
    end else begin
      card_reset_ctrl_in_q <= card_reset_ctrl_in_s;
      card_reset <= rst_en & card_reset_ctrl_in_s & ~(state == S_DEACT);
      case (state)
        S_IDLE: begin
          timer <= 12'h000;
          step <= 3'h0;
          if (!cmd_n_s && presence_hi_db && !stop_req && !fault_latch) begin
            state <= S_ACT;
            boost_enable <= 1'b1;
            supply_level_high <= level_s;
          end
        end
        S_ACT: begin
          if (stop_req) begin
            state <= S_DEACT;
            rst_en <= 1'b0;
            timer <= 12'h000;
            step <= 3'h0;
          end else begin
            if (step >= 3'h2 && card_reset_ctrl_in_fall) begin
              clk_run <= 1'b1;
            end
            if (step_done) begin
              timer <= 12'h000;
              step <= step + 3'h1;
              case (step)
                3'h0: card_supply_enable <= 1'b1;
                3'h1: lines_en <= 1'b1;
                3'h3: begin
                  clk_run <= 1'b1;
                  rst_en <= 1'b1;
                  state <= S_ON;
                end
                default: ;
              endcase
            end else begin
              timer <= timer + 12'h001;
            end
          end
        end
        S_ON: begin
          if (stop_req) begin
            state <= S_DEACT;
            rst_en <= 1'b0;
            timer <= 12'h000;
            step <= 3'h0;
          end
        end
        S_DEACT: begin
          // Four fixed steps of 10 us keep the whole sequence under 100 us
          if (deact_done) begin
            timer <= 12'h000;
            step <= step + 3'h1;
            case (step)
              3'h0: clk_run <= 1'b0;
              3'h1: lines_en <= 1'b0;
              3'h2: card_supply_enable <= 1'b0;
              3'h3: begin
                boost_enable <= 1'b0;
                state <= S_IDLE;
              end
              default: ;
            endcase
          end else begin
            timer <= timer + 12'h001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Fault latch: set by a fault outside S_IDLE, cleared in S_IDLE once the command is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_latch <= 1'b0;
      fault_presence_irq_n_oe <= 1'b1;
    end else begin
      if (fault_now && state != S_IDLE) begin
        fault_latch <= 1'b1;
      end else if (state == S_IDLE && cmd_n_s) begin
        fault_latch <= 1'b0;
      end
      fault_presence_irq_n_oe <= fault_latch | ~presence_hi_db;
    end
  end

  assign fault_presence_irq_n_out = 1'b0;

  card_clock_gen u_clk (
    .pclk(pclk),
    .presetn(presetn),
    .osc_level(osc_s),
    .clock_div_sel_a(div_a_s),
    .clock_div_sel_b(div_b_s),
    .run(clk_run),
    .card_clk(card_clk),
    .running(clk_running)
  );

  // Two-way lines: whichever side pulls low first owns the line
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_line
      reg own_host;
      reg own_card;
      reg [2:0] guard;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          own_host <= 1'b0;
          own_card <= 1'b0;
          guard <= 3'h0;
        end else if (!lines_en) begin
          own_host <= 1'b0;
          own_card <= 1'b0;
          guard <= `LINE_GUARD_CYC;
        end else if (own_host) begin
          if (host_in_s[gi]) begin
            own_host <= 1'b0;
            guard <= `LINE_GUARD_CYC; // Lets the far side rise, no lock-up
          end
        end else if (own_card) begin
          if (card_in_s[gi]) begin
            own_card <= 1'b0;
            guard <= `LINE_GUARD_CYC;
          end
        end else if (guard != 3'h0) begin
          guard <= guard - 3'h1;
        end else if (!host_in_s[gi]) begin
          own_host <= 1'b1;
        end else if (!card_in_s[gi]) begin
          own_card <= 1'b1;
        end
      end
      assign card_oe[gi] = own_host | ~lines_en;
      assign host_oe[gi] = own_card;
    end
  endgenerate

  assign host_side_data_line_out = 1'b0;
  assign host_side_extra_line_a_out = 1'b0;
  assign host_side_extra_line_b_out = 1'b0;
  assign card_side_data_line_out = 1'b0;
  assign card_side_extra_line_a_out = 1'b0;
  assign card_side_extra_line_b_out = 1'b0;
  assign host_side_data_line_oe = host_oe[0];
  assign host_side_extra_line_a_oe = host_oe[1];
  assign host_side_extra_line_b_oe = host_oe[2];
  assign card_side_data_line_oe = card_oe[0];
  assign card_side_extra_line_a_oe = card_oe[1];
  assign card_side_extra_line_b_oe = card_oe[2];

  // APB slave, zero wait states; read data captured in setup
  assign addr_ok = (paddr == `REG_STEP_LEN) || (paddr == `REG_STATUS);
  assign bus_setup = psel & ~penable;
  assign bus_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_len <= `STEP_LEN_RST;
      prdata <= 32'h00000000;
    end else begin
      if (bus_wr && paddr == `REG_STEP_LEN) begin
        step_len <= pwdata[`STEP_LEN_W-1:0];
      end
      if (bus_setup && !pwrite) begin
        prdata <= 32'h00000000;
        if (paddr == `REG_STEP_LEN) begin
          prdata[`STEP_LEN_W-1:0] <= step_len;
        end else if (paddr == `REG_STATUS) begin
          prdata[`ST_STATE_LSB+3:`ST_STATE_LSB] <= state;
          prdata[`ST_PRESENT] <= presence_hi_db;
          prdata[`ST_FAULT_LATCH] <= fault_latch;
          prdata[`ST_IRQ_LOW] <= fault_presence_irq_n_oe;
          prdata[`ST_OVERLOAD] <= overload_s;
          prdata[`ST_OVERHEAT] <= heat_s;
          prdata[`ST_BOOST_FAULT] <= boost_f_s;
          prdata[`ST_SUPERVISOR] <= sup_active;
          prdata[`ST_CLK_RUN] <= clk_running;
          prdata[`ST_SUPPLY_EN] <= card_supply_enable;
        end
      end
    end
  end
endmodule // card_seq

// ### verif/card_seq_monitor.sv
/* Checker for card_seq: sequencing order, irq and card clock relations.
   Assumes it is bound onto card_seq with pclk at 25 MHz. */
`timescale 1ns/1ns
module card_seq_monitor (
  input logic pclk,
  input logic presetn,
  input logic activate_cmd_n,
  input logic supply_overload,
  input logic supply_level_sel,
  input logic fault_presence_irq_n_out,
  input logic fault_presence_irq_n_oe,
  input logic boost_enable,
  input logic card_supply_enable,
  input logic supply_level_high,
  input logic card_reset,
  input logic card_clk,
  input logic card_side_data_line_oe,
  input logic card_side_extra_line_a_oe,
  input logic card_side_extra_line_b_oe,
  input logic supervisor_hold
);
  // 100 us at 25 MHz, plus slack for the input synchroniser
  localparam int DEACT_LIMIT = 2504;
  logic [15:0] deact_cnt;
  logic [3:0] hi_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deact_cnt <= 16'h0000;
      hi_len <= 4'h0;
    end else begin
      deact_cnt <= (activate_cmd_n && boost_enable) ? deact_cnt + 16'h0001 : 16'h0000;
      hi_len <= !card_clk ? 4'h0 : (hi_len == 4'hF) ? hi_len : hi_len + 4'h1;
    end
  end
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_irq_pull_only; fault_presence_irq_n_out == 1'b0; endproperty
  a_irq_pull_only: assert property (p_irq_pull_only) else $error("irq line driven high");
  property p_supply_boost; card_supply_enable |-> boost_enable; endproperty
  a_supply_boost: assert property (p_supply_boost) else $error("supply without boost");
  property p_lines_low; !card_supply_enable |-> card_side_data_line_oe && card_side_extra_line_a_oe
    && card_side_extra_line_b_oe && !card_reset; endproperty
  a_lines_low: assert property (p_lines_low) else $error("card lines live without supply");
  property p_clk_supply; $rose(card_clk) |-> card_supply_enable
    && !(card_side_data_line_oe && card_side_extra_line_a_oe && card_side_extra_line_b_oe); endproperty
  a_clk_supply: assert property (p_clk_supply) else $error("card clock before lines");
  property p_reset_first; $rose(activate_cmd_n) && card_reset |-> ##[1:4] (!card_reset && card_supply_enable);
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("card reset not dropped first");
  property p_fault_irq; $rose(supply_overload) && card_supply_enable |-> ##[1:5] fault_presence_irq_n_oe;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("overload not flagged");
  property p_deact_bound; deact_cnt <= DEACT_LIMIT; endproperty
  a_deact_bound: assert property (p_deact_bound) else $error("deactivation too slow");
  property p_no_short_pulse; $fell(card_clk) |-> hi_len >= 4'h3; endproperty
  a_no_short_pulse: assert property (p_no_short_pulse) else $error("short card clock pulse");
  property p_no_card; $rose(boost_enable) |-> !fault_presence_irq_n_oe; endproperty
  a_no_card: assert property (p_no_card) else $error("activation while irq low");
  property p_level; card_supply_enable |-> supply_level_high == supply_level_sel; endproperty
  a_level: assert property (p_level) else $error("wrong supply level");
  c_reset_up: cover property ($rose(card_reset));
  c_boost_off: cover property ($fell(boost_enable));
  c_supervisor: cover property ($rose(supervisor_hold));
endmodule // card_seq_monitor

bind card_seq card_seq_monitor mon_u (.pclk, .presetn, .activate_cmd_n, .supply_overload, .supply_level_sel,
  .fault_presence_irq_n_out, .fault_presence_irq_n_oe, .boost_enable, .card_supply_enable, .supply_level_high,
  .card_reset, .card_clk, .card_side_data_line_oe, .card_side_extra_line_a_oe, .card_side_extra_line_b_oe,
  .supervisor_hold);

// ### verif/host_mcu_model.sv
/* Host microcontroller model: drives the session command and reset control.
   Assumes the irq wire is already resolved with its pull-up. */
`timescale 1ns/1ns
module host_mcu_model #(
  parameter int RETRY_GAP = 250000,
  parameter int IRQ_HOLD = 6500
) (
  input logic pclk,
  input logic irq_n,
  output logic activate_cmd_n,
  output logic card_reset_ctrl_in
);
  initial begin
    activate_cmd_n = 1'b1;
    card_reset_ctrl_in = 1'b1;
  end
  // Insist only when a scenario asks for a request without a card
  task automatic open_session(input int gap, input bit insist);
    int k;
    k = 0;
    while (!insist && irq_n !== 1'b1 && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    @(posedge pclk);
    activate_cmd_n <= 1'b0;
    repeat (gap) @(posedge pclk);
    card_reset_ctrl_in <= 1'b0;
  endtask
  task automatic release_reset();
    @(posedge pclk);
    card_reset_ctrl_in <= 1'b1;
  endtask
  task automatic close_session(input bit after_irq, input bit slow_retry);
    if (after_irq) repeat (IRQ_HOLD) @(posedge pclk);
    @(posedge pclk);
    activate_cmd_n <= 1'b1;
    card_reset_ctrl_in <= 1'b1;
    if (slow_retry) repeat (RETRY_GAP) @(posedge pclk);
  endtask
endmodule // host_mcu_model

// ### verif/test_smart_card_activation_sequencer.sv
/* Bench for card_seq: APB, presence, sessions, faults, lines, supervisor.
   Assumes the host model drives the command pins; pull-ups on all lines. */
`timescale 1ns/1ns
`include "card_seq_consts.vh"
module test_smart_card_activation_sequencer;
  localparam [19:0] DEB = 20'h00032;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic presence_hi = 0, presence_lo = 1, supply_overload = 0, overheat = 0, boost_fault = 0, core_supply_low = 0;
  logic supervisor_threshold_adj = 0, clock_div_sel_a = 0, clock_div_sel_b = 0, supply_level_sel = 1, osc_input = 0;
  logic activate_cmd_n, card_reset_ctrl_in, irq_oe, irq_out, boost_enable, card_supply_enable, supply_level_high;
  logic card_reset, card_clk, supervisor_hold;
  logic [2:0] host_drv = 3'h7, card_drv = 3'h7;
  wire [2:0] host_oe, card_oe, host_out, card_out;
  wire [2:0] host_w = host_drv & ~(host_oe & ~host_out);
  wire [2:0] card_w = card_drv & ~(card_oe & ~card_out);
  wire irq_n = irq_oe ? irq_out : 1'b1;
  int fail_count = 0, n_tests = 0;
  always #20 pclk = ~pclk;
  always #160 osc_input = ~osc_input;
  card_seq #(.DEBOUNCE_CYCLES(DEB), .SUP_SHORT_CYCLES(20'h00028), .SUP_LONG_CYCLES(20'h00050)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .activate_cmd_n,
    .card_reset_ctrl_in, .presence_hi, .presence_lo, .supply_overload, .overheat, .boost_fault, .core_supply_low,
    .supervisor_threshold_adj, .clock_div_sel_a, .clock_div_sel_b, .supply_level_sel, .osc_input,
    .host_side_data_line_in(host_w[0]), .host_side_data_line_out(host_out[0]), .host_side_data_line_oe(host_oe[0]),
    .host_side_extra_line_a_in(host_w[1]), .host_side_extra_line_a_out(host_out[1]),
    .host_side_extra_line_a_oe(host_oe[1]), .host_side_extra_line_b_in(host_w[2]),
    .host_side_extra_line_b_out(host_out[2]), .host_side_extra_line_b_oe(host_oe[2]),
    .card_side_data_line_in(card_w[0]), .card_side_data_line_out(card_out[0]), .card_side_data_line_oe(card_oe[0]),
    .card_side_extra_line_a_in(card_w[1]), .card_side_extra_line_a_out(card_out[1]),
    .card_side_extra_line_a_oe(card_oe[1]), .card_side_extra_line_b_in(card_w[2]),
    .card_side_extra_line_b_out(card_out[2]), .card_side_extra_line_b_oe(card_oe[2]),
    .fault_presence_irq_n_out(irq_out), .fault_presence_irq_n_oe(irq_oe), .boost_enable, .card_supply_enable,
    .supply_level_high, .card_reset, .card_clk, .supervisor_hold);
  host_mcu_model #(.RETRY_GAP(200)) host_u (.pclk, .irq_n, .activate_cmd_n, .card_reset_ctrl_in);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return boost_enable;
      1: return card_supply_enable;
      2: return !card_oe[0];
      3: return card_clk;
      4: return card_reset;
      5: return !card_reset_ctrl_in;
      6: return !card_clk;
      7: return supervisor_hold;
      8: return !supervisor_hold;
      9: return !irq_oe;
      10: return irq_oe;
      default: return !boost_enable;
    endcase
  endfunction
  // Bounded wait; running out is itself a mismatch
  task automatic wt(input int s, input int lim, output int n);
    n = 0;
    while (sig(s) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(n < lim, 1'b1);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic per(output int n);
    int a, b;
    wt(6, 100, a);
    wt(3, 100, b);
    n = a + b;
  endtask
  task automatic t_regs();
    apb(1'b0, `REG_STEP_LEN, 32'h0);
    chk(rd, {20'h00000, `STEP_LEN_RST});
    apb(1'b1, `REG_STEP_LEN, 32'h00000014);
    apb(1'b0, `REG_STEP_LEN, 32'h0);
    chk(rd, 32'h00000014);
    apb(1'b1, `REG_STATUS, 32'hFFFFFFFF);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd, 32'h00000041);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
  endtask
  task automatic t_session(input logic lvl, input bit full);
    int n, i;
    logic [1:0] sel [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    int dv [4] = '{8, 4, 2, 1};
    supply_level_sel <= lvl;
    fork host_u.open_session(55, 1'b0); join_none
    wt(0, 200, n);
    wt(1, 200, n);
    chk(n, 21);
    wt(2, 200, n);
    chk(n, 21);
    chk(supply_level_high, lvl);
    wt(5, 200, n);
    wt(3, 50, n);
    chk(n <= 40, 1'b1);
    chk(card_reset, 1'b0);
    repeat (30) @(posedge pclk);
    host_u.release_reset();
    wt(4, 10, n);
    for (i = 0; full && i < 4; i++) begin
      {clock_div_sel_a, clock_div_sel_b} <= sel[i];
      repeat (3) per(n);
      per(n);
      chk(n, 8 * dv[i]);
    end
    for (i = 0; full && i < 3; i++) begin
      host_drv[i] <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(card_oe[i], 1'b1);
      host_drv[i] <= 1'b1;
      repeat (12) @(posedge pclk);
      card_drv[i] <= 1'b0;
      repeat (5) @(posedge pclk);
      chk({host_oe[i], card_oe[i]}, 2'b10);
      card_drv[i] <= 1'b1;
      repeat (12) @(posedge pclk);
    end
    host_u.close_session(1'b0, 1'b0);
    wt(11, 2600, n);
    chk(irq_oe, 1'b0);
  endtask
  task automatic t_faults();
    int n, i;
    for (i = 0; i < 3; i++) begin
      fork host_u.open_session(55, 1'b0); join_none
      wt(1, 300, n);
      {boost_fault, overheat, supply_overload} <= 3'b001 << i;
      wt(10, 6, n);
      wt(11, 2600, n);
      {boost_fault, overheat, supply_overload} <= 3'b000;
      host_u.close_session(1'b1, i == 2);
      wt(9, 10, n);
    end
  endtask
  task automatic t_presence();
    int n, i;
    fork host_u.open_session(55, 1'b0); join_none
    wt(1, 300, n);
    presence_hi <= 1'b0;
    wt(10, 70, n);
    wt(11, 2600, n);
    host_u.close_session(1'b1, 1'b0);
    repeat (10) @(posedge pclk);
    chk(irq_oe, 1'b1);
    fork host_u.open_session(5, 1'b1); join_none
    repeat (200) @(posedge pclk);
    chk(boost_enable, 1'b0);
    host_u.close_session(1'b0, 1'b0);
    presence_lo <= 1'b0;
    wt(9, 100, n);
    chk(n >= DEB, 1'b1);
    for (i = 0; i < 2; i++) begin
      supervisor_threshold_adj <= i[0];
      core_supply_low <= 1'b1;
      repeat (3) @(posedge pclk);
      core_supply_low <= 1'b0;
      wt(7, 10, n);
      wt(8, 200, n);
      chk(n >= 36 + 40 * i && n <= 46 + 40 * i, 1'b1);
      repeat (20) @(posedge pclk);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    int n;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    chk(irq_oe, 1'b1);
    presence_hi <= 1'b1;
    wt(9, 100, n);
    chk(n >= DEB, 1'b1);
    t_session(1'b1, 1'b1);
    t_session(1'b0, 1'b0);
    t_faults();
    t_presence();
    wrap_up();
  end
  // Roughly 34k cycles are needed; cut off at 60k
  initial begin
    #2400000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // test_smart_card_activation_sequencer
